// *** logic/sdma_card_end.sv ***
`timescale 1ns/1ps
module sdma_card_end
	import sdma_pkg::*;
#(
	parameter int unsigned WAIT_CYC  = REQ_WAIT_CYC,
	parameter int unsigned MAX_HALT  = MAX_HALT_CYCLES
)(
	input  wire logic              mclk_i,
	input  wire logic              reset_n_i,
	sdma_bus_if.card               bus,
	input  wire logic              start_i,
	input  wire logic              rw_n_i,
	input  wire logic [ADDR_W-1:0] addr_i,
	input  wire logic [LEN_W-1:0]  len_i,
	input  wire logic [DATA_W-1:0] wdata_i,
	output logic                   busy_o,
	output logic                   wr_take_o,
	output logic      [DATA_W-1:0] rdata_o,
	output logic                   rdata_valid_o,
	output logic                   done_o
);

	// drive point after the video edge: the wait, but never past setup;
	// the 213 ns figure is used for both host models since it meets both
	localparam int unsigned DRIVE_CYC =
		(WAIT_CYC < ADDR_SETUP_CYC) ? WAIT_CYC : ADDR_SETUP_CYC;
	localparam logic [PCNT_W-1:0] DRIVE_AT = PCNT_W'(DRIVE_CYC - 1);
	localparam logic [PCNT_W-1:0] DEN_AT   = PCNT_W'(DATA_EN_CYC - 1);
	localparam logic [PCNT_W-1:0] DOFF_AT  = PCNT_W'(PHASE_CYC - 2);
	localparam logic [PCNT_W-1:0] RD_AT    = PCNT_W'(READ_CYC);
	localparam logic [LEN_W-1:0]  HALT_MAX = LEN_W'(MAX_HALT);

	sdma_card_st_t     st_q;
	logic              vp_q;
	logic [PCNT_W-1:0] ph_cnt_q;
	logic              dma_oe_q;
	logic              addr_oe_q;
	logic [ADDR_W-1:0] addr_q;
	logic              rw_n_q;
	logic [DATA_W-1:0] wdata_q;
	logic              data_oe_q;
	logic [LEN_W-1:0]  left_q;
	logic [LEN_W-1:0]  halt_q;
	logic              busy_q;
	logic              take_q;
	logic [DATA_W-1:0] rdata_q;
	logic              rvalid_q;
	logic              done_q;
	logic              vid_rise;
	logic              vid_edge;
	logic              in_cpu;
	logic              more;
	logic [LEN_W-1:0]  len_clip;

	assign vid_edge = bus.video_phase ^ vp_q;
	assign vid_rise = bus.video_phase & ~vp_q;
	assign in_cpu   = bus.cpu_phase_clock;
	// another byte only while the halt budget allows it
	assign more     = (left_q > LEN_W'(1)) && (halt_q + 1'b1 < HALT_MAX);
	assign len_clip = (len_i == '0) ? LEN_W'(1) :
		((len_i > HALT_MAX) ? HALT_MAX : len_i);

	// phase position counted from each video phase edge, so every card
	// time is referred to the host edge and not to a free-running count
	always_ff @(posedge mclk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			vp_q     <= VIDEO_PHASE_RST;
			ph_cnt_q <= '0;
		end
		else
		begin
			vp_q <= bus.video_phase;
			if (vid_edge)
				ph_cnt_q <= '0;
			else if (ph_cnt_q != '1)
				ph_cnt_q <= ph_cnt_q + 1'b1;
		end
	end

	// sequencer: arm, request, wait, own the bus, release
	always_ff @(posedge mclk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			st_q <= SDMA_IDLE;
		else
		begin
			unique case (st_q)
				SDMA_IDLE:
					if (start_i)
						st_q <= SDMA_ARM;
				SDMA_ARM:
					if (vid_rise)
						st_q <= SDMA_WAIT;
				SDMA_WAIT:
					if (ph_cnt_q == DRIVE_AT)
						st_q <= SDMA_XFER;
				SDMA_XFER:
					if (vid_rise && !more)
						st_q <= SDMA_IDLE;
				default:
					st_q <= SDMA_IDLE;
			endcase
		end
	end

	// request line: falls at a video edge, rises only at a video edge,
	// so the host transceiver never turns during a cpu phase
	always_ff @(posedge mclk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			dma_oe_q <= 1'b0;
		else if (st_q == SDMA_ARM && vid_rise)
			dma_oe_q <= 1'b1;
		else if (st_q == SDMA_XFER && vid_rise && !more)
			dma_oe_q <= 1'b0;
	end

	// address and rw: driven after the wait, well inside the setup time
	always_ff @(posedge mclk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			addr_oe_q <= 1'b0;
		else if (st_q == SDMA_WAIT && ph_cnt_q == DRIVE_AT)
			addr_oe_q <= 1'b1;
		else if (st_q == SDMA_XFER && vid_rise && !more)
			addr_oe_q <= 1'b0;
	end

	// transfer address, direction and byte count
	always_ff @(posedge mclk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			addr_q <= '0;
			rw_n_q <= 1'b1;
			left_q <= '0;
		end
		else if (st_q == SDMA_IDLE && start_i)
		begin
			addr_q <= addr_i;
			rw_n_q <= rw_n_i;
			left_q <= len_clip;
		end
		else if (st_q == SDMA_XFER && vid_rise && more)
		begin
			// next address lands at once, far ahead of the setup limit
			addr_q <= addr_q + 1'b1;
			left_q <= left_q - 1'b1;
		end
	end

	// cpu phases spent with the processor halted
	always_ff @(posedge mclk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			halt_q <= '0;
		else if (st_q == SDMA_IDLE)
			halt_q <= '0;
		else if (st_q == SDMA_XFER && vid_rise)
			halt_q <= halt_q + 1'b1;
	end

	// write byte taken from the user at each start of a byte
	always_ff @(posedge mclk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			wdata_q <= '0;
			take_q  <= 1'b0;
		end
		else
		begin
			take_q <= 1'b0;
			if ((st_q == SDMA_IDLE && start_i && !rw_n_i) ||
				(st_q == SDMA_XFER && vid_rise && more && !rw_n_q))
			begin
				wdata_q <= wdata_i;
				take_q  <= 1'b1;
			end
		end
	end

	// write data only after the host transceiver has turned inward, and
	// off again before the video phase so no fight at the next edge
	always_ff @(posedge mclk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			data_oe_q <= 1'b0;
		else if (st_q == SDMA_XFER && in_cpu && !rw_n_q &&
			ph_cnt_q == DEN_AT)
			data_oe_q <= 1'b1;
		else if (ph_cnt_q == DOFF_AT || vid_edge)
			data_oe_q <= 1'b0;
	end

	// read data sampled once valid, well before the cpu phase ends
	always_ff @(posedge mclk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			rdata_q  <= '0;
			rvalid_q <= 1'b0;
		end
		else
		begin
			rvalid_q <= 1'b0;
			if (st_q == SDMA_XFER && in_cpu && rw_n_q && ph_cnt_q == RD_AT)
			begin
				rdata_q  <= bus.data;
				rvalid_q <= 1'b1;
			end
		end
	end

	// status towards the user
	always_ff @(posedge mclk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			busy_q <= 1'b0;
			done_q <= 1'b0;
		end
		else
		begin
			done_q <= (st_q == SDMA_XFER && vid_rise && !more);
			if (st_q == SDMA_IDLE && start_i)
				busy_q <= 1'b1;
			else if (st_q == SDMA_XFER && vid_rise && !more)
				busy_q <= 1'b0;
		end
	end

	// open-drain request: only ever pulled low
	assign bus.card_dma_o   = 1'b0;
	assign bus.card_dma_oe  = dma_oe_q;
	assign bus.card_addr_o  = addr_q;
	assign bus.card_rw_n_o  = rw_n_q;
	assign bus.card_addr_oe = addr_oe_q;
	assign bus.card_data_o  = wdata_q;
	assign bus.card_data_oe = data_oe_q;
	assign busy_o           = busy_q;
	assign wr_take_o        = take_q;
	assign rdata_o          = rdata_q;
	assign rdata_valid_o    = rvalid_q;
	assign done_o           = done_q;

endmodule

// *** logic/sdma_pkg.sv ***
package sdma_pkg;

	// slot bus widths
	localparam int unsigned ADDR_W = 16;
	localparam int unsigned DATA_W = 8;

	// clock and phase timing
	localparam int unsigned CLK_PERIOD_NS = 5;
	localparam int unsigned PHASE_NS      = 490;
	localparam int unsigned PHASE_CYC     = PHASE_NS / CLK_PERIOD_NS;
	localparam int unsigned PCNT_W        = 7;
	localparam logic [PCNT_W-1:0] PHASE_LAST = PCNT_W'(PHASE_CYC - 1);
	localparam logic [PCNT_W-1:0] PHASE_HALF = PCNT_W'(PHASE_CYC / 2);

	// host: address buffer release after the request falls (longest time)
	localparam int unsigned BUF_DIS_NS  = 25;
	localparam int unsigned GATE_NS     = 5;
	localparam int unsigned REL_MAX_CYC =
		(BUF_DIS_NS + GATE_NS) / CLK_PERIOD_NS;

	// card: wait after the request before driving (least time)
	localparam int unsigned REQ_WAIT_NS  = 30;
	localparam int unsigned REQ_WAIT_CYC =
		(REQ_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// card: address and rw valid after the video phase rises (longest)
	localparam int unsigned ADDR_SETUP_NS      = 213;
	localparam int unsigned ADDR_SETUP_CYC     = ADDR_SETUP_NS / CLK_PERIOD_NS;
	localparam int unsigned ADDR_SETUP_OLD_NS  = 300;
	localparam int unsigned ADDR_SETUP_OLD_CYC =
		ADDR_SETUP_OLD_NS / CLK_PERIOD_NS;

	// data timing inside the cpu phase
	localparam int unsigned DATA_EN_NS    = 155;
	localparam int unsigned DATA_EN_CYC   =
		(DATA_EN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned CAS_NS        = 210;
	localparam int unsigned CAS_CYC       = CAS_NS / CLK_PERIOD_NS;
	localparam int unsigned READ_VALID_NS = 345;
	localparam int unsigned READ_CYC      =
		(READ_VALID_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// longest processor halt, in cpu phase cycles
	localparam int unsigned MAX_HALT_CYCLES = 10;
	localparam int unsigned LEN_W           = 4;

	// reset values
	localparam logic VIDEO_PHASE_RST = 1'b1;

	// card sequencer states, one-hot
	typedef enum logic [3:0] {
		SDMA_IDLE = 4'b0001,
		SDMA_ARM  = 4'b0010,
		SDMA_WAIT = 4'b0100,
		SDMA_XFER = 4'b1000
	} sdma_card_st_t;

endpackage

// *** logic/sdma_bus_if.sv ***
`timescale 1ns/1ps
interface sdma_bus_if;
	import sdma_pkg::*;

	// phase timing from the host
	logic              video_phase;
	logic              cpu_phase_clock;
	// request line, open drain, card side only
	logic              card_dma_o;
	logic              card_dma_oe;
	logic              dma_req_n;
	// address and rw, shared
	logic [ADDR_W-1:0] host_addr_o;
	logic              host_addr_oe;
	logic              host_rw_n_o;
	logic [ADDR_W-1:0] card_addr_o;
	logic              card_addr_oe;
	logic              card_rw_n_o;
	logic [ADDR_W-1:0] addr;
	logic              rw_n;
	// data, shared
	logic [DATA_W-1:0] host_data_o;
	logic              host_data_oe;
	logic [DATA_W-1:0] card_data_o;
	logic              card_data_oe;
	logic [DATA_W-1:0] data;

	// wire levels; undriven lines float high through pull-ups
	assign dma_req_n = card_dma_oe ? card_dma_o : 1'b1;
	assign addr = card_addr_oe ? card_addr_o :
		(host_addr_oe ? host_addr_o : '1);
	assign rw_n = card_addr_oe ? card_rw_n_o :
		(host_addr_oe ? host_rw_n_o : 1'b1);
	assign data = card_data_oe ? card_data_o :
		(host_data_oe ? host_data_o : '1);

	modport host (
		output video_phase, cpu_phase_clock,
		output host_addr_o, host_addr_oe, host_rw_n_o,
		output host_data_o, host_data_oe,
		input  dma_req_n, addr, rw_n, data
	);

	modport card (
		input  video_phase, cpu_phase_clock,
		output card_dma_o, card_dma_oe,
		output card_addr_o, card_addr_oe, card_rw_n_o,
		output card_data_o, card_data_oe,
		input  dma_req_n, addr, rw_n, data
	);

endinterface

// *** logic/sdma_host_end.sv ***
`timescale 1ns/1ps
module sdma_host_end
	import sdma_pkg::*;
#(
	parameter bit OLD_MODEL = 1'b0,
	parameter int MEM_AW    = 10
)(
	input  wire logic              mclk_i,
	input  wire logic              reset_n_i,
	sdma_bus_if.host               bus,
	input  wire logic [ADDR_W-1:0] cpu_addr_i,
	input  wire logic              cpu_rw_n_i,
	input  wire logic [DATA_W-1:0] cpu_wdata_i,
	output logic      [DATA_W-1:0] cpu_rdata_o,
	output logic                   cpu_halt_o,
	output logic      [7:0]        ram_addr_o,
	output logic                   ram_hi_o
);

	logic [PCNT_W-1:0] cnt_q;
	logic              vp_q;
	logic              cpu_clk_q;
	logic              own_q;
	logic              halt_q;
	logic              addr_oe_q;
	logic [ADDR_W-1:0] addr_q;
	logic              rw_q;
	logic [ADDR_W-1:0] vid_q;
	logic [DATA_W-1:0] dout_q;
	logic              dout_oe_q;
	logic [DATA_W-1:0] rdata_q;
	logic [7:0]        ram_addr_q;
	logic              ram_hi_q;
	logic [DATA_W-1:0] mem [2**MEM_AW];
	logic              dma_low;
	logic              phase_end;
	logic [ADDR_W-1:0] acc_addr;
	logic              acc_rw_n;
	logic              wr_slot;

	assign dma_low   = ~bus.dma_req_n;
	assign phase_end = (cnt_q == PHASE_LAST);
	// card owns the cpu phase only if it held the request through video
	assign acc_addr  = vp_q ? vid_q : (own_q ? bus.addr : addr_q);
	assign acc_rw_n  = vp_q ? 1'b1 : (own_q ? bus.rw_n : rw_q);
	// older host: request forces cpu buffer inward, slot data reaches ram
	assign wr_slot   = own_q | (OLD_MODEL & dma_low);

	// two-phase timing; cpu phase clock is the inverse of the video phase
	always_ff @(posedge mclk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			cnt_q     <= '0;
			vp_q      <= VIDEO_PHASE_RST;
			cpu_clk_q <= ~VIDEO_PHASE_RST;
		end
		else if (phase_end)
		begin
			cnt_q     <= '0;
			vp_q      <= ~vp_q;
			cpu_clk_q <= vp_q;
		end
		else
			cnt_q <= cnt_q + 1'b1;
	end

	// bus ownership decided at the end of each video phase
	always_ff @(posedge mclk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			own_q  <= 1'b0;
			halt_q <= 1'b0;
		end
		else
		begin
			halt_q <= dma_low;
			if (phase_end && vp_q)
				own_q <= dma_low;
		end
	end

	// address buffers let go one cycle after the request falls
	always_ff @(posedge mclk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			addr_oe_q <= 1'b0;
			addr_q    <= '0;
			rw_q      <= 1'b1;
		end
		else
		begin
			addr_oe_q <= ~dma_low;
			addr_q    <= cpu_addr_i;
			rw_q      <= cpu_rw_n_i;
		end
	end

	// transceiver: outward on reads, off on slot writes, inward on cpu
	// writes; which rw it obeys is steered by the request line
	always_ff @(posedge mclk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			dout_oe_q <= 1'b0;
			dout_q    <= '0;
		end
		else
		begin
			dout_oe_q <= dma_low ? bus.rw_n : rw_q;
			dout_q    <= mem[acc_addr[MEM_AW-1:0]];
		end
	end

	// video refresh walks memory during every video phase
	always_ff @(posedge mclk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			vid_q <= '0;
		else if (phase_end && vp_q)
			vid_q <= vid_q + 1'b1;
	end

	// ram address bus: low byte first, high byte in the second half
	always_ff @(posedge mclk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			ram_addr_q <= '0;
			ram_hi_q   <= 1'b0;
		end
		else
		begin
			ram_hi_q   <= (cnt_q >= PHASE_HALF);
			ram_addr_q <= (cnt_q >= PHASE_HALF) ?
				acc_addr[15:8] : acc_addr[7:0];
		end
	end

	// memory access at the column strobe point of the cpu phase
	always_ff @(posedge mclk_i)
	begin
		if (!vp_q && cnt_q == PCNT_W'(CAS_CYC) && !acc_rw_n)
			mem[acc_addr[MEM_AW-1:0]] <= wr_slot ? bus.data : cpu_wdata_i;
	end

	// processor read data, held while the processor is halted
	always_ff @(posedge mclk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			rdata_q <= '0;
		else if (!vp_q && !own_q && cnt_q == PCNT_W'(CAS_CYC))
			rdata_q <= mem[acc_addr[MEM_AW-1:0]];
	end

	assign bus.video_phase     = vp_q;
	assign bus.cpu_phase_clock = cpu_clk_q;
	assign bus.host_addr_oe    = addr_oe_q;
	assign bus.host_addr_o     = addr_q;
	assign bus.host_rw_n_o     = rw_q;
	assign bus.host_data_oe    = dout_oe_q;
	assign bus.host_data_o     = dout_q;
	assign cpu_rdata_o         = rdata_q;
	assign cpu_halt_o          = halt_q;
	assign ram_addr_o          = ram_addr_q;
	assign ram_hi_o            = ram_hi_q;

endmodule

// *** sim/sdma_bus_checker.sv ***
`timescale 1ns/1ps
module sdma_bus_checker
	import sdma_pkg::*;
(
	input wire logic mclk_i,
	input wire logic reset_n_i,
	input wire logic video_phase,
	input wire logic cpu_phase_clock,
	input wire logic dma_req_n,
	input wire logic host_addr_oe,
	input wire logic card_addr_oe,
	input wire logic host_data_oe,
	input wire logic card_data_oe
);
	localparam int REL_MAX   = REL_MAX_CYC;
	localparam int SETUP_MAX = ADDR_SETUP_CYC;
	localparam int EN_MIN    = DATA_EN_CYC;
	logic [7:0] vcnt_q;
	logic [7:0] ccnt_q;
	logic [4:0] hcnt_q;

	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!reset_n_i);

	// cycles spent so far in the current video and cpu phases
	always_ff @(posedge mclk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			vcnt_q <= 8'h00;
			ccnt_q <= 8'h00;
		end
		else
		begin
			vcnt_q <= video_phase ? vcnt_q + 8'h01 : 8'h00;
			ccnt_q <= cpu_phase_clock ? ccnt_q + 8'h01 : 8'h00;
		end
	end

	// cpu phases lost by the processor in one hold of the request
	always_ff @(posedge mclk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			hcnt_q <= 5'h00;
		else if (dma_req_n)
			hcnt_q <= 5'h00;
		else if ($fell(cpu_phase_clock))
			hcnt_q <= hcnt_q + 5'h01;
	end

	property p_phase_inv;
		cpu_phase_clock == !video_phase;
	endproperty
	a_phase_inv: assert property (p_phase_inv)
		else $error("cpu phase clock not inverse of video phase");

	property p_req_fall;
		$fell(dma_req_n) |-> video_phase;
	endproperty
	a_req_fall: assert property (p_req_fall)
		else $error("request lowered in cpu phase");

	property p_req_rise;
		$rose(dma_req_n) |-> video_phase;
	endproperty
	a_req_rise: assert property (p_req_rise)
		else $error("request released in cpu phase");

	property p_host_rel;
		$fell(dma_req_n) |-> ##[1:REL_MAX] !host_addr_oe;
	endproperty
	a_host_rel: assert property (p_host_rel)
		else $error("host kept address bus after request");

	property p_card_wait;
		$fell(dma_req_n) |-> !card_addr_oe [*6];
	endproperty
	a_card_wait: assert property (p_card_wait)
		else $error("card drove address too soon after request");

	property p_setup;
		$rose(card_addr_oe) |-> video_phase && vcnt_q <= SETUP_MAX;
	endproperty
	a_setup: assert property (p_setup)
		else $error("card address late in video phase");

	property p_data_en;
		$rose(card_data_oe) |-> cpu_phase_clock && ccnt_q >= EN_MIN;
	endproperty
	a_data_en: assert property (p_data_en)
		else $error("card data enabled too early");

	property p_addr_one;
		!(host_addr_oe && card_addr_oe);
	endproperty
	a_addr_one: assert property (p_addr_one)
		else $error("address bus driven by both ends");

	property p_data_one;
		!(host_data_oe && card_data_oe);
	endproperty
	a_data_one: assert property (p_data_one)
		else $error("data bus driven by both ends");

	property p_own;
		card_addr_oe |-> !dma_req_n;
	endproperty
	a_own: assert property (p_own)
		else $error("card drives address without request");

	property p_halt;
		hcnt_q <= 5'h0a;
	endproperty
	a_halt: assert property (p_halt)
		else $error("processor halted too long");

	c_req: cover property ($fell(dma_req_n));
	c_wr: cover property ($rose(card_data_oe));
	c_halt_max: cover property (hcnt_q == 5'h0a);
endmodule

// *** sim/tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
	import sdma_pkg::*;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
	} sdma_rd_t;

	logic              mclk_i;
	logic              reset_n_i;
	logic              start_i;
	logic              rw_n_i;
	logic [ADDR_W-1:0] addr_i;
	logic [LEN_W-1:0]  len_i;
	logic [DATA_W-1:0] wdata_i;
	logic [ADDR_W-1:0] cpu_addr_i;
	logic              cpu_rw_n_i;
	logic [DATA_W-1:0] cpu_wdata_i;
	logic [DATA_W-1:0] cpu_rdata_o;
	logic              cpu_halt_o;
	logic [7:0]        ram_addr_o;
	logic              ram_hi_o;
	logic              prev_halt;
	logic [DATA_W-1:0] held_rd;
	logic              busy_o;
	logic              wr_take_o;
	logic [DATA_W-1:0] rdata_o;
	logic              rdata_valid_o;
	logic              done_o;
	logic [DATA_W-1:0] mem [0:1023];
	sdma_rd_t          rd_q [$];
	sdma_rd_t          exp_rd;
	int                done_q [$];
	int                exp_n;
	int                seen;
	int                n_mismatch;
	int                n_compared;
	int                base;
	int                ln;

	sdma_bus_if sdma_bus_if_i ();

	sdma_host_end sdma_host_end_i (
		.mclk_i      (mclk_i),
		.reset_n_i   (reset_n_i),
		.bus         (sdma_bus_if_i),
		.cpu_addr_i  (cpu_addr_i),
		.cpu_rw_n_i  (cpu_rw_n_i),
		.cpu_wdata_i (cpu_wdata_i),
		.cpu_rdata_o (cpu_rdata_o),
		.cpu_halt_o  (cpu_halt_o),
		.ram_addr_o  (ram_addr_o),
		.ram_hi_o    (ram_hi_o)
	);

	sdma_card_end sdma_card_end_i (
		.mclk_i        (mclk_i),
		.reset_n_i     (reset_n_i),
		.bus           (sdma_bus_if_i),
		.start_i       (start_i),
		.rw_n_i        (rw_n_i),
		.addr_i        (addr_i),
		.len_i         (len_i),
		.wdata_i       (wdata_i),
		.busy_o        (busy_o),
		.wr_take_o     (wr_take_o),
		.rdata_o       (rdata_o),
		.rdata_valid_o (rdata_valid_o),
		.done_o        (done_o)
	);

	sdma_bus_checker sdma_bus_checker_i (
		.mclk_i          (mclk_i),
		.reset_n_i       (reset_n_i),
		.video_phase     (sdma_bus_if_i.video_phase),
		.cpu_phase_clock (sdma_bus_if_i.cpu_phase_clock),
		.dma_req_n       (sdma_bus_if_i.dma_req_n),
		.host_addr_oe    (sdma_bus_if_i.host_addr_oe),
		.card_addr_oe    (sdma_bus_if_i.card_addr_oe),
		.host_data_oe    (sdma_bus_if_i.host_data_oe),
		.card_data_oe    (sdma_bus_if_i.card_data_oe)
	);

	always #2.5 mclk_i = ~mclk_i;

	task automatic test_done();
		if (n_mismatch == 0 && n_compared > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic chk_rd(input sdma_rd_t got, input sdma_rd_t exp);
		n_compared++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("BAD %0t read got %h want %h", $time, got, exp);
		end
	endtask

	task automatic chk_done(input int got, input int exp);
		n_compared++;
		if (got != exp)
		begin
			n_mismatch++;
			$display("BAD %0t bytes got %0d want %0d", $time, got, exp);
		end
	endtask

	task automatic chk_halt(input logic got, input logic exp);
		n_compared++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("BAD %0t halt got %b want %b", $time, got, exp);
		end
	endtask

	task automatic chk_ram(input logic [8:0] got, input logic [8:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("BAD %0t ram address got %h want %h", $time, got, exp);
		end
	endtask

	task automatic chk_cpurd(input logic [DATA_W-1:0] got,
		input logic [DATA_W-1:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("BAD %0t cpu data got %h want %h", $time, got, exp);
		end
	endtask

	// one transfer; poke retries start while busy, which must be ignored
	task automatic xfer(input logic rw, input int a, input int len,
		input bit poke);
		int n;
		int j;
		n = (len == 0) ? 1 : ((len > 10) ? 10 : len);
		for (j = 0; j < n; j++)
		begin
			if (!rw)
				mem[a + j] = 8'($urandom);
			else
				rd_q.push_back({16'(a + j), mem[a + j]});
		end
		done_q.push_back(n);
		@(negedge mclk_i);
		start_i = 1'b1;
		rw_n_i = rw;
		addr_i = 16'(a);
		len_i = 4'(len);
		wdata_i = rw ? 8'($urandom) : mem[a];
		@(negedge mclk_i);
		start_i = 1'b0;
		j = 1;
		// no limit here: a transfer that never ends is caught by the guard
		for (int k = 0; done_o !== 1'b1; k++)
		begin
			// next byte goes up once the last one was taken
			if (!rw && wr_take_o === 1'b1 && j < n)
			begin
				wdata_i = mem[a + j];
				j++;
			end
			start_i = poke && (k == 4);
			addr_i = poke ? 16'($urandom) : addr_i;
			@(negedge mclk_i);
		end
		repeat ($urandom_range(1, 120)) @(negedge mclk_i);
	endtask

	// processor side reads and writes random places, kept to the upper
	// half of memory so it never disturbs the transferred bytes
	always @(negedge mclk_i)
	begin
		cpu_addr_i = 16'($urandom) | 16'h0200;
		cpu_rw_n_i = 1'($urandom);
		cpu_wdata_i = 8'($urandom);
	end

	// scoreboard: match each result against the oldest note
	always @(negedge mclk_i)
	begin
		if (rdata_valid_o === 1'b1)
		begin
			exp_rd = (rd_q.size() > 0) ? rd_q.pop_front() : 'x;
			chk_rd({sdma_bus_if_i.addr, rdata_o}, exp_rd);
			chk_ram({ram_hi_o, ram_addr_o},
				{1'b1, exp_rd.addr[15:8]});
		end
		// processor halted while the card owns the bus, free when idle
		if (rdata_valid_o === 1'b1 || done_o === 1'b1)
			chk_halt(cpu_halt_o, 1'b1);
		else if (busy_o === 1'b0)
			chk_halt(cpu_halt_o, 1'b0);
		// processor read data must stay put while it is halted
		if (cpu_halt_o === 1'b1 && prev_halt !== 1'b1)
			held_rd = cpu_rdata_o;
		if (done_o === 1'b1)
			chk_cpurd(cpu_rdata_o, held_rd);
		prev_halt = cpu_halt_o;
		seen += (wr_take_o === 1'b1) + (rdata_valid_o === 1'b1);
		if (done_o === 1'b1)
		begin
			exp_n = (done_q.size() > 0) ? done_q.pop_front() : -1;
			chk_done(seen, exp_n);
			seen = 0;
		end
	end

	initial
	begin
		void'($urandom(32'h571b));
		mclk_i = 1'b0;
		reset_n_i = 1'b0;
		start_i = 1'b0;
		rw_n_i = 1'b1;
		addr_i = '0;
		len_i = '0;
		wdata_i = '0;
		cpu_addr_i = '0;
		cpu_wdata_i = '0;
		cpu_rw_n_i = 1'b1;
		prev_halt = 1'b0;
		held_rd = '0;
		n_mismatch = 0;
		n_compared = 0;
		seen = 0;
		repeat (3) @(posedge mclk_i);
		@(negedge mclk_i);
		reset_n_i = 1'b1;
		// write then read back; lengths hit zero and above the cap
		for (int i = 0; i < 4; i++)
		begin
			base = 16 * $urandom_range(0, 30);
			ln = (i == 0) ? 0 : ((i == 1) ? 15 : $urandom_range(1, 10));
			xfer(1'b0, base, ln, i == 2);
			xfer(1'b1, base, ln, i == 3);
		end
		test_done();
	end

	// hang guard, about four times the longest planned run
	initial
	begin
		repeat (60000) @(posedge mclk_i);
		n_mismatch++;
		test_done();
	end
endmodule
